// >>> common/bmt_cfg.svh
// constants of the battery monitor and timer register block
`ifndef BMT_CFG_SVH
`define BMT_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define BMT_OFS_LIMIT 8'h09
`define BMT_OFS_MON 8'h0A
`define BMT_OFS_TMR 8'h0B

// ************************************************************
// field positions
// ************************************************************
`define BMT_BIT_TRIGGER 7
`define BMT_BIT_GLOBAL_RESET 7

// ************************************************************
// reset values and special field codes
// ************************************************************
`define BMT_RST_MON 8'h00
`define BMT_RST_TMR 8'h42
`define BMT_BAND_TOP 2'h3
`define BMT_STEP_NONE 3'h0
`define BMT_LIMIT_OFF 2'h3

// ************************************************************
// bus address and timing
// ************************************************************
`define BMT_I2C_ADDR 7'h35
`define BMT_SETTLE_NS 1000
`define BMT_CLK_MHZ 20

`endif

// >>> common/bmt_pkg.sv
// types of the battery monitor and timer register block
package bmt_pkg;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_TXACK
  } bmt_i2c_st_t;

  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} bmt_kind_t;

  typedef enum logic {M_IDLE, M_RUN} bmt_mon_st_t;

  typedef struct packed {
    logic [1:0] band;
    logic [2:0] step;
  } bmt_result_t;

  typedef struct packed {
    logic droop_disable;
    logic [2:0] droop_threshold;
    logic halfspeed_enable;
    logic [1:0] limit_select;
  } bmt_timer_ctrl_t;

endpackage : bmt_pkg

// >>> verification/bmt_host.sv
// i2c host model driving the bus pins of the register block
`timescale 1ns/1ps
`include "bmt_cfg.svh"
module bmt_host
(
  input wire logic clk,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic scl,
  output logic sda
);
  logic low_q = 1'b0;
  int half = 4;
  initial scl = 1'b1;
  // pull-up: line low when host pulls it or device drives a zero
  assign sda = !(low_q || (dev_oe && !dev_out));
  task automatic tick();
    repeat (half) @(negedge clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    tick();
    low_q = !b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    low_q = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    low_q = 1'b1;
    tick();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick();
    low_q = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    low_q = 1'b0;
    tick();
  endtask : stop
  task automatic byte_x(input logic [7:0] o, input logic m,
                        output logic [7:0] i, output logic nak);
    for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
    bit_io(m, nak);
  endtask : byte_x
  task automatic wr(input logic [6:0] a, input logic [7:0] r,
                    input logic [7:0] d, output logic nak);
    logic [7:0] i;
    logic n0, n1, n2;
    start();
    byte_x({a, 1'b0}, 1'b1, i, n0);
    byte_x(r, 1'b1, i, n1);
    byte_x(d, 1'b1, i, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask : wr
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic [7:0] i;
    logic n;
    start();
    byte_x({`BMT_I2C_ADDR, 1'b0}, 1'b1, i, n);
    byte_x(r, 1'b1, i, n);
    start();
    byte_x({`BMT_I2C_ADDR, 1'b1}, 1'b1, i, n);
    byte_x(8'hFF, 1'b1, d, n);
    stop();
  endtask : rd
endmodule : bmt_host

// >>> verification/bmt_regs_sva.sv
// port assertions of the monitor and timer register block
`timescale 1ns/1ps
module bmt_regs_sva
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SDA_OE,
  input wire logic LOW_POWER_ENTRY,
  input wire logic CHARGE_CC,
  input wire logic CHARGE_CV,
  input wire logic [1:0] MON_BAND_SEL,
  input wire logic MON_BUSY,
  input wire logic DROOP_DISABLE,
  input wire logic [2:0] DROOP_THRESHOLD,
  input wire logic TIMER_SLOW,
  input wire logic [1:0] SAFETY_LIMIT_SEL,
  input wire logic SAFETY_TIMER_OFF
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  property p_off;
    SAFETY_TIMER_OFF == (SAFETY_LIMIT_SEL == 2'h3);
  endproperty
  a_off: assert property (p_off)
    else $error("timer off decode");
  property p_wr;
    $changed({DROOP_DISABLE, DROOP_THRESHOLD, SAFETY_LIMIT_SEL})
      |-> $rose(SDA_OE);
  endproperty
  a_wr: assert property (p_wr)
    else $error("control moved off ack");
  property p_slow;
    (CHARGE_CC || CHARGE_CV) [*5] |-> !TIMER_SLOW;
  endproperty
  a_slow: assert property (p_slow)
    else $error("slowed in cc or cv");
  property p_top;
    $rose(MON_BUSY) |-> MON_BAND_SEL == 2'h3;
  endproperty
  a_top: assert property (p_top)
    else $error("search not at top");
  property p_down;
    MON_BUSY && $past(MON_BUSY) && $changed(MON_BAND_SEL)
      |-> MON_BAND_SEL == $past(MON_BAND_SEL) - 2'h1;
  endproperty
  a_down: assert property (p_down)
    else $error("band skip");
  property p_bound;
    $rose(MON_BUSY) |-> ##[1:82] !MON_BUSY;
  endproperty
  a_bound: assert property (p_bound)
    else $error("search too long");
  property p_lp;
    $rose(LOW_POWER_ENTRY) && !MON_BUSY |-> ##[1:6] MON_BUSY;
  endproperty
  a_lp: assert property (p_lp)
    else $error("no search on sleep");
  property p_rst;
    $rose(NRST) |-> DROOP_THRESHOLD == 3'h4 && SAFETY_LIMIT_SEL == 2'h1
      && !DROOP_DISABLE;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bad reset value");
endmodule : bmt_regs_sva

// >>> verification/tb_bmt_regs.sv
// self-checking bench of the monitor and timer register block
`timescale 1ns/1ps
`include "bmt_cfg.svh"
module tb_bmt_regs;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic lp = 1'b0;
  logic cc = 1'b0;
  logic cv = 1'b0;
  logic [2:0] raw = 3'h0;
  logic [1:0] tgt_band = 2'h0;
  logic [2:0] tgt_step = 3'h0;
  logic scl, sda, oe, sdo, busy, dd, slow, toff, nak;
  logic [1:0] bsel, lsel;
  logic [2:0] thr;
  logic [7:0] rnd = 8'h3E;
  logic [7:0] d, v;
  int fail_count = 0;
  int check_count = 0;
  bmt_host host (.clk(clk), .dev_oe(oe), .dev_out(sdo), .scl(scl),
    .sda(sda));
  bmt_regs dut (.SYS_CLK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sdo), .SDA_OE(oe), .LOW_POWER_ENTRY(lp), .MON_STEP_RAW(raw),
    .CHARGE_CC(cc), .CHARGE_CV(cv), .MON_BAND_SEL(bsel), .MON_BUSY(busy),
    .DROOP_DISABLE(dd), .DROOP_THRESHOLD(thr), .TIMER_SLOW(slow),
    .SAFETY_LIMIT_SEL(lsel), .SAFETY_TIMER_OFF(toff));
  initial forever #25 clk = !clk;
  // battery sits in one band: only that band gives a step code
  always @(negedge clk) raw <= (bsel == tgt_band) ? tgt_step : 3'h0;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [7:0] mon_exp(input logic [1:0] b,
                                         input logic [2:0] s);
    return (s == 3'h0) ? 8'h00 : {1'b0, b, s, 2'h0};
  endfunction : mon_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic search(input logic [1:0] b, input logic [2:0] s,
                        input logic by_lp);
    tgt_band = b;
    tgt_step = s;
    repeat (4) @(negedge clk);
    if (by_lp)
      lp = 1'b1;
    else
      host.wr(`BMT_I2C_ADDR, `BMT_OFS_MON, 8'h80, nak);
    repeat (8) @(negedge clk);
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk);
    lp = 1'b0;
    host.rd(`BMT_OFS_MON, d);
    chk(d, mon_exp(b, s));
  endtask : search
  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    host.rd(`BMT_OFS_MON, d);
    chk(d, `BMT_RST_MON);
    host.rd(`BMT_OFS_TMR, d);
    chk(d, `BMT_RST_TMR);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      host.half = 4 + rnd[1:0];
      cc = rnd[5];
      cv = rnd[6] & rnd[0];
      v = (k == 0) ? 8'hFE : {rnd[7:3], k[1:0], 1'b0};
      host.wr(`BMT_I2C_ADDR, `BMT_OFS_TMR, v, nak);
      chk(nak, 1'b0);
      host.rd(`BMT_OFS_TMR, d);
      chk(d, v);
      chk({dd, thr, slow, lsel, toff}, {v[7:4], v[3] & !cc & !cv, v[2:1],
          v[2:1] == 2'h3});
    end
    $display("test timer done");
    search(2'h3, 3'h7, 1'b0);
    search(2'h2, 3'h3, 1'b0);
    search(2'h1, 3'h6, 1'b0);
    search(2'h0, 3'h1, 1'b0);
    search(2'h2, 3'h0, 1'b0);
    search(2'h1, 3'h2, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      search(rnd[1:0], rnd[4:2], rnd[5]);
    end
    $display("test monitor done");
    host.wr(`BMT_I2C_ADDR, `BMT_OFS_TMR, 8'hB5, nak);
    host.wr(`BMT_I2C_ADDR, `BMT_OFS_LIMIT, 8'h80, nak);
    host.rd(`BMT_OFS_LIMIT, d);
    chk(d, 8'h00);
    host.rd(`BMT_OFS_TMR, d);
    chk(d, `BMT_RST_TMR);
    host.rd(`BMT_OFS_MON, d);
    chk(d, `BMT_RST_MON);
    host.wr(`BMT_I2C_ADDR ^ 7'h01, `BMT_OFS_TMR, 8'h00, nak);
    chk(nak, 1'b1);
    host.rd(`BMT_OFS_TMR, d);
    chk(d, `BMT_RST_TMR);
    $display("test global reset done");
    wrap_up();
  end
  // more than twice the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : tb_bmt_regs
bind bmt_regs bmt_regs_sva sva (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .SDA_OE(SDA_OE), .LOW_POWER_ENTRY(LOW_POWER_ENTRY),
  .CHARGE_CC(CHARGE_CC), .CHARGE_CV(CHARGE_CV),
  .MON_BAND_SEL(MON_BAND_SEL), .MON_BUSY(MON_BUSY),
  .DROOP_DISABLE(DROOP_DISABLE), .DROOP_THRESHOLD(DROOP_THRESHOLD),
  .TIMER_SLOW(TIMER_SLOW), .SAFETY_LIMIT_SEL(SAFETY_LIMIT_SEL),
  .SAFETY_TIMER_OFF(SAFETY_TIMER_OFF));

// >>> verilog/bmt_regs.sv
// battery monitor and droop/timer registers behind an i2c slave
//
// Overview of operation
// - writing one to monitor bit 7 starts a search; bit 7 reads zero
// - two-bit band field: 11 top band down to 00 lowest band
// - three-bit step code in band; 000 means threshold not met
// - search starts at band 11, steps down while step code is 000
// - no band gives nonzero step: band and step load all zeros
// - a search also runs automatically before low-power entry
// - droop threshold code with 400/200/100 mV weights; top bit disables
// - half-speed bit slows safety timer outside CC and CV control
// - two-bit safety limit select; code 11 disables safety timers
// - global reset bit at 0x09 restores defaults; reads back zero
`timescale 1ns/1ps
`include "bmt_cfg.svh"
module bmt_regs
  import bmt_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic LOW_POWER_ENTRY,
  input wire logic [2:0] MON_STEP_RAW,
  input wire logic CHARGE_CC,
  input wire logic CHARGE_CV,
  output logic [1:0] MON_BAND_SEL,
  output logic MON_BUSY,
  output logic DROOP_DISABLE,
  output logic [2:0] DROOP_THRESHOLD,
  output logic TIMER_SLOW,
  output logic [1:0] SAFETY_LIMIT_SEL,
  output logic SAFETY_TIMER_OFF
);
  localparam int SETTLE_CYC = (`BMT_SETTLE_NS * `BMT_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [2:0] prev_q;
  logic scl_s, sda_s, lp_s, cc_s, cv_s;
  logic [2:0] step_s;
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {SCL, SDA_IN, LOW_POWER_ENTRY, MON_STEP_RAW,
                  CHARGE_CC, CHARGE_CV};
      sync2_q <= sync1_q;
      prev_q <= {sync2_q[7], sync2_q[6], sync2_q[5]};
    end
  end
  assign scl_s = sync2_q[7];
  assign sda_s = sync2_q[6];
  assign lp_s = sync2_q[5];
  assign step_s = sync2_q[4:2];
  assign cc_s = sync2_q[1];
  assign cv_s = sync2_q[0];
  logic scl_rise, scl_fall, i2c_start, i2c_stop, lp_rise;
  assign scl_rise = scl_s & ~prev_q[2];
  assign scl_fall = ~scl_s & prev_q[2];
  assign i2c_start = scl_s & prev_q[2] & prev_q[1] & ~sda_s;
  assign i2c_stop = scl_s & prev_q[2] & ~prev_q[1] & sda_s;
  assign lp_rise = lp_s & ~prev_q[0];
  // ************************************************************
  // i2c slave and control register
  // ************************************************************
  bmt_i2c_st_t st_q, st_d;
  bmt_kind_t kind_q, kind_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic [2:0] cnt_q, cnt_d;
  logic full_q, full_d, tx_next_q, tx_next_d, nack_q, nack_d;
  logic oe_q, oe_d, slow_q, slow_d;
  bmt_timer_ctrl_t tmr_q, tmr_d;
  logic wr_trig, wr_grst;
  bmt_result_t res_q, res_d;
  logic [7:0] rd_val;
  assign rd_val =
    (ptr_q == `BMT_OFS_MON) ? {1'b0, res_q, 2'b00} :
    (ptr_q == `BMT_OFS_TMR) ? {tmr_q, 1'b0} : 8'h00;
  always_comb
  begin
    st_d = st_q;
    kind_d = kind_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    full_d = full_q;
    tx_next_d = tx_next_q;
    nack_d = nack_q;
    oe_d = oe_q;
    tmr_d = tmr_q;
    wr_trig = 1'b0;
    wr_grst = 1'b0;
    if (i2c_start || i2c_stop)
    begin
      st_d = i2c_start ? I2C_RX : I2C_IDLE;
      kind_d = K_ADDR;
      cnt_d = 3'h0;
      full_d = 1'b0;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        I2C_RX:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 3'h1;
            full_d = (cnt_q == 3'h7);
          end
          else if (scl_fall && full_q)
          begin
            full_d = 1'b0;
            oe_d = 1'b1;
            st_d = I2C_ACK;
            case (kind_q)
              K_ADDR:
              begin
                tx_next_d = sh_q[0];
                kind_d = K_REG;
                if (sh_q[7:1] != `BMT_I2C_ADDR)
                begin
                  oe_d = 1'b0;
                  st_d = I2C_IDLE;
                end
              end
              K_REG:
              begin
                ptr_d = sh_q;
                kind_d = K_DATA;
              end
              default:
              begin
                ptr_d = ptr_q + 8'h01;
                if (ptr_q == `BMT_OFS_TMR)
                  tmr_d = bmt_timer_ctrl_t'(sh_q[7:1]);
                if (ptr_q == `BMT_OFS_MON)
                  wr_trig = sh_q[`BMT_BIT_TRIGGER];
                if (ptr_q == `BMT_OFS_LIMIT)
                  wr_grst = sh_q[`BMT_BIT_GLOBAL_RESET];
              end
            endcase
          end
        end
        I2C_ACK, I2C_TXACK:
        begin
          if (scl_rise && st_q == I2C_TXACK)
            nack_d = sda_s;
          else if (scl_fall)
          begin
            cnt_d = 3'h0;
            oe_d = 1'b0;
            if (st_q == I2C_TXACK && nack_q)
              st_d = I2C_IDLE;
            else if (tx_next_q)
            begin
              sh_d = rd_val;
              oe_d = ~rd_val[7];
              ptr_d = ptr_q + 8'h01;
              st_d = I2C_TX;
            end
            else
              st_d = I2C_RX;
          end
        end
        I2C_TX:
          if (scl_fall)
          begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6] & (cnt_q != 3'h7);
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7)
              st_d = I2C_TXACK;
          end
        default: oe_d = 1'b0;
      endcase
    end
    if (wr_grst)
      tmr_d = bmt_timer_ctrl_t'(`BMT_RST_TMR >> 1);
    slow_d = tmr_q.halfspeed_enable & ~cc_s & ~cv_s;
  end
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q <= I2C_IDLE;
      kind_q <= K_ADDR;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      tx_next_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      slow_q <= 1'b0;
      tmr_q <= bmt_timer_ctrl_t'(`BMT_RST_TMR >> 1);
    end
    else
    begin
      st_q <= st_d;
      kind_q <= kind_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      tx_next_q <= tx_next_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      slow_q <= slow_d;
      tmr_q <= tmr_d;
    end
  end
  // ************************************************************
  // band and step search
  // ************************************************************
  bmt_mon_st_t mst_q, mst_d;
  logic [1:0] sel_q, sel_d;
  logic [7:0] wait_q, wait_d;
  always_comb
  begin
    mst_d = mst_q;
    sel_d = sel_q;
    wait_d = wait_q;
    res_d = res_q;
    case (mst_q)
      M_IDLE:
        if (wr_trig || lp_rise)
        begin
          mst_d = M_RUN;
          sel_d = `BMT_BAND_TOP;
          wait_d = 8'h00;
        end
      M_RUN:
        if (wait_q != SETTLE_LAST)
          wait_d = wait_q + 8'h01;
        // band 00 with no step also lands here and stores 00 000
        else if (step_s != `BMT_STEP_NONE || sel_q == 2'h0)
        begin
          res_d = '{band: sel_q, step: step_s};
          mst_d = M_IDLE;
        end
        else
        begin
          sel_d = sel_q - 2'h1;
          wait_d = 8'h00;
        end
      default: mst_d = M_IDLE;
    endcase
    if (wr_grst)
    begin
      mst_d = M_IDLE;
      res_d = bmt_result_t'(`BMT_RST_MON >> 2);
    end
  end
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      mst_q <= M_IDLE;
      sel_q <= `BMT_BAND_TOP;
      wait_q <= 8'h00;
      res_q <= bmt_result_t'(`BMT_RST_MON >> 2);
    end
    else
    begin
      mst_q <= mst_d;
      sel_q <= sel_d;
      wait_q <= wait_d;
      res_q <= res_d;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_q;
  assign MON_BAND_SEL = sel_q;
  assign MON_BUSY = (mst_q == M_RUN);
  assign DROOP_DISABLE = tmr_q.droop_disable;
  assign DROOP_THRESHOLD = tmr_q.droop_threshold;
  assign TIMER_SLOW = slow_q;
  assign SAFETY_LIMIT_SEL = tmr_q.limit_select;
  assign SAFETY_TIMER_OFF = (tmr_q.limit_select == `BMT_LIMIT_OFF);
endmodule : bmt_regs
